/* File: pulse_link_pkg.sv */
// Shared constants and carriers, plus the input conditioning filter.
`timescale 1ns/10ps
`default_nettype none
package pulse_link_pkg;
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned FAST_HZ    = 10_000;
  localparam int unsigned SLOW_HZ    = 10;
  localparam int unsigned FILTER_US  = 1_000;
  localparam int unsigned LED_MS     = 50;
  localparam int unsigned BLINK_MS   = 250;
  localparam int unsigned HALF_FAST  = CLK_HZ / (2 * FAST_HZ);
  localparam int unsigned HALF_SLOW  = CLK_HZ / (2 * SLOW_HZ);
  localparam int unsigned FILTER_CYC = (CLK_HZ / 1_000_000) * FILTER_US;
  localparam int unsigned LED_CYC    = (CLK_HZ / 1_000) * LED_MS;
  localparam int unsigned BLINK_CYC  = (CLK_HZ / 1_000) * BLINK_MS;
  localparam int unsigned CNT_W      = 27;
  localparam int unsigned ACC_W      = 30;
  localparam int unsigned ADDR_W     = 8;
  localparam logic [3:0]  OFS_CTRL    = 4'h0;
  localparam logic [3:0]  OFS_STATUS  = 4'h4;
  localparam logic [3:0]  OFS_COUNT   = 4'h8;
  localparam logic [3:0]  OFS_BACKLOG = 4'hC;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  typedef struct packed {
    logic [11:0]       spare;
    logic [ADDR_W-1:0] out_addr;
    logic [ADDR_W-1:0] in_addr;
    logic              out_mode_freq;
    logic              in_mode_freq;
    logic              out_rate_slow;
    logic              in_speed_low;
  } ctrl_t;

  typedef struct packed {
    logic link_up;
    logic primary_ok;
    logic addr_mismatch;
    logic mode_mismatch;
  } status_t;
endpackage

module pulse_input_filter #(
  parameter int unsigned FILT = pulse_link_pkg::FILTER_CYC
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin,
  input  wire logic filt_en,
  output logic      level
);
  logic                             sync_a;
  logic                             sync_b;
  logic [pulse_link_pkg::CNT_W-1:0] cnt;
  wire                              differs = sync_b != level;
  wire                              settled = cnt == pulse_link_pkg::CNT_W'(FILT - 1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  // A level must hold for the whole window before it is believed, which rejects chatter.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= 1'b0;
      cnt   <= '0;
    end else if (!differs) begin
      cnt <= '0;
    end else if (!filt_en || settled) begin
      level <= sync_b;
      cnt   <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  a_filter_hold: assert property (@(posedge clk) disable iff (!rst_b)
    filt_en && $past(filt_en) && $changed(level) |->
    $past(cnt) == pulse_link_pkg::CNT_W'(FILT - 1))
    else $error("filtered level moved before the settle window");
endmodule
`default_nettype wire

/* File: pulse_count_link_outage_buffer.sv */
// Pulse count transfer with outage retention, pulse regeneration and status lamp.
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pulse_count_link_outage_buffer #(
  parameter int unsigned HALF_FAST = pulse_link_pkg::HALF_FAST,
  parameter int unsigned HALF_SLOW = pulse_link_pkg::HALF_SLOW,
  parameter int unsigned FILT      = pulse_link_pkg::FILTER_CYC,
  parameter int unsigned LED_HOLD  = pulse_link_pkg::LED_CYC,
  parameter int unsigned BLINK     = pulse_link_pkg::BLINK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        pulse_pin,
  input  wire logic        link_pin,
  input  wire logic        primary_pin,
  output logic             pulse_out,
  output logic             status_led,
  output logic             pulse_led
);
  localparam int unsigned W = pulse_link_pkg::CNT_W;
  localparam int unsigned A = pulse_link_pkg::ACC_W;

  typedef enum logic [1:0] {
    EMIT_IDLE = 2'b00,
    EMIT_HIGH = 2'b01,
    EMIT_LOW  = 2'b10
  } emit_t;

  pulse_link_pkg::ctrl_t   ctrl;
  pulse_link_pkg::status_t stat;
  emit_t                   emit;
  logic [A-1:0]            in_count;
  logic [A-1:0]            rx_last;
  logic [A-1:0]            backlog;
  logic [W-1:0]            tick;
  logic [W-1:0]            led_cnt;
  logic [W-1:0]            blink_cnt;
  logic                    level;
  logic                    level_d;
  logic [1:0]              link_s;
  logic [1:0]              prim_s;

  pulse_input_filter #(.FILT(FILT)) u_filter (
    .clk     (clk),
    .rst_b   (rst_b),
    .pin     (pulse_pin),
    .filt_en (ctrl.in_speed_low),
    .level   (level)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_s <= 2'b00;
      prim_s <= 2'b00;
    end else begin
      link_s <= {link_s[0], link_pin};
      prim_s <= {prim_s[0], primary_pin};
    end
  end

  function automatic logic [W-1:0] to_cnt(input int unsigned n);
    return W'(n - 1);
  endfunction

  wire              edge_seen  = level && !level_d;
  wire              link_up    = link_s[1];
  wire              primary_ok = prim_s[1];
  wire              addr_mm    = ctrl.in_addr != ctrl.out_addr;
  wire              mode_mm    = ctrl.in_mode_freq != ctrl.out_mode_freq;
  wire              fault      = !link_up || addr_mm || mode_mm;
  wire              tx_ok      = link_up && primary_ok && !addr_mm && !mode_mm;
  wire              tx_now     = tx_ok && (in_count != rx_last);
  // Subtraction at the accumulator width wraps naturally, so a roll past zero stays correct.
  wire [A-1:0]      delta      = tx_now ? A'(in_count - rx_last) : '0;
  wire              tick_done  = tick == '0;
  // A pulse may follow straight out of the low half, so back-to-back pulses keep 50% duty.
  wire              start      = ((emit == EMIT_IDLE) || ((emit == EMIT_LOW) && tick_done)) &&
                                 (backlog != '0);
  wire [W-1:0]      half_sel   = ctrl.out_rate_slow ? to_cnt(HALF_SLOW) : to_cnt(HALF_FAST);
  wire [A-1:0]      next_backlog = A'(backlog + delta - {{(A-1){1'b0}}, start});

  always_comb begin
    stat.link_up       = link_up;
    stat.primary_ok    = primary_ok;
    stat.addr_mismatch = addr_mm;
    stat.mode_mismatch = mode_mm;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_d  <= 1'b0;
      in_count <= '0;
    end else begin
      level_d <= level;
      if (edge_seen) begin
        in_count <= A'(in_count + 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_last <= '0;
      backlog <= '0;
    end else begin
      if (tx_now) begin
        rx_last <= in_count;
      end
      backlog <= next_backlog;
    end
  end

  // Pulse regeneration: one pulse per backlog unit, equal high and low halves.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      emit      <= EMIT_IDLE;
      tick      <= '0;
      pulse_out <= 1'b0;
    end else begin
      case (emit)
        EMIT_IDLE: begin
          if (start) begin
            emit      <= EMIT_HIGH;
            tick      <= half_sel;
            pulse_out <= 1'b1;
          end
        end
        EMIT_HIGH: begin
          if (tick_done) begin
            emit      <= EMIT_LOW;
            tick      <= half_sel;
            pulse_out <= 1'b0;
          end else begin
            tick <= tick - 1'b1;
          end
        end
        EMIT_LOW: begin
          if (start) begin
            emit      <= EMIT_HIGH;
            tick      <= half_sel;
            pulse_out <= 1'b1;
          end else if (tick_done) begin
            emit <= EMIT_IDLE;
          end else begin
            tick <= tick - 1'b1;
          end
        end
        default: begin
          emit      <= EMIT_IDLE;
          pulse_out <= 1'b0;
        end
      endcase
    end
  end

  // Lamps: the input lamp is stretched so a short pulse is still visible.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      led_cnt    <= '0;
      pulse_led  <= 1'b0;
      blink_cnt  <= '0;
      status_led <= 1'b0;
    end else begin
      if (edge_seen) begin
        led_cnt   <= to_cnt(LED_HOLD);
        pulse_led <= 1'b1;
      end else if (led_cnt != '0) begin
        led_cnt <= led_cnt - 1'b1;
      end else begin
        pulse_led <= 1'b0;
      end
      if (!fault) begin
        blink_cnt  <= '0;
        status_led <= 1'b1;
      end else if (blink_cnt == '0) begin
        blink_cnt  <= to_cnt(BLINK);
        status_led <= !status_led;
      end else begin
        blink_cnt <= blink_cnt - 1'b1;
      end
    end
  end

  // Wishbone slave: answer one cycle after the strobe; only wb_adr_i[3:2] is decoded, so the four words repeat.
  wire         wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [3:0]   wb_ofs    = {wb_adr_i[3:2], 2'b00};
  // The write lands at the edge where the master samples ack, while its data still stands.
  wire         ctrl_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
                           (wb_ofs == pulse_link_pkg::OFS_CTRL);
  wire [31:0]  ctrl_word = ctrl;
  wire [31:0]  rd_word   = (wb_ofs == pulse_link_pkg::OFS_CTRL)    ? ctrl_word :
                           (wb_ofs == pulse_link_pkg::OFS_STATUS)  ? {28'h0000000, stat} :
                           (wb_ofs == pulse_link_pkg::OFS_COUNT)   ? {2'b00, in_count} :
                           (wb_ofs == pulse_link_pkg::OFS_BACKLOG) ? {2'b00, backlog} :
                           32'h0000_0000;
  wire [31:0]  sel_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0]  ctrl_new  = (ctrl_word & ~sel_mask) | (wb_dat_i & sel_mask);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl     <= pulse_link_pkg::CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_word : 32'h0000_0000;
      if (ctrl_wr) begin
        ctrl <= {12'h000, ctrl_new[19:0]};
      end
    end
  end

  sequence s_pulse_start;
    emit == EMIT_IDLE && backlog != '0;
  endsequence

  sequence s_pulse_up;
    pulse_out && emit == EMIT_HIGH;
  endsequence

  a_count_step: assert property (@(posedge clk) disable iff (!rst_b)
    edge_seen |=> in_count == A'($past(in_count) + 1'b1))
    else $error("accumulated count missed a detected pulse");

  a_hold_offline: assert property (@(posedge clk) disable iff (!rst_b)
    !(link_up && primary_ok) |=> $stable(rx_last))
    else $error("count was sent without link or primary power");

  a_send_on_link: assert property (@(posedge clk) disable iff (!rst_b)
    tx_ok && in_count != rx_last |=> rx_last == $past(in_count))
    else $error("present count not sent when the link was usable");

  a_pair_blocked: assert property (@(posedge clk) disable iff (!rst_b)
    addr_mm || mode_mm |=> $stable(rx_last) && $stable(backlog) || $past(start))
    else $error("mismatched pair exchanged a count");

  a_backlog_diff: assert property (@(posedge clk) disable iff (!rst_b)
    tx_now && !start |=> backlog == A'($past(backlog) + $past(in_count) - $past(rx_last)))
    else $error("owed pulses not raised by the wrapped difference");

  a_drain_start: assert property (@(posedge clk) disable iff (!rst_b)
    s_pulse_start |=> s_pulse_up)
    else $error("owed pulse not started");

  a_rate_load: assert property (@(posedge clk) disable iff (!rst_b)
    s_pulse_start |=> tick == ($past(ctrl.out_rate_slow) ? to_cnt(HALF_SLOW) : to_cnt(HALF_FAST)))
    else $error("pulse half period does not follow the rate bit");

  a_status_ok: assert property (@(posedge clk) disable iff (!rst_b)
    !fault [*2] |-> status_led)
    else $error("status lamp not steady with a healthy pair");

  a_status_flash: assert property (@(posedge clk) disable iff (!rst_b)
    fault && blink_cnt == '0 |=> status_led != $past(status_led))
    else $error("status lamp not flashing on a fault");

  a_lamp_flash: assert property (@(posedge clk) disable iff (!rst_b)
    edge_seen |=> pulse_led)
    else $error("input lamp did not light on a pulse");

  a_lamp_dark: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(pulse_led) |-> $past(edge_seen))
    else $error("input lamp lit without a pulse");
endmodule
`default_nettype wire

/* File: remote_pulse_model.sv */
// Behavioural model of the remote input unit: pulse source, link and supply state.
`timescale 1ns/10ps
`default_nettype none
module remote_pulse_model (
  input  wire logic clk,
  output logic      pulse_pin,
  output logic      link_pin,
  output logic      primary_pin
);
  initial begin
    pulse_pin = 1'b0;
    link_pin = 1'b0;
    primary_pin = 1'b0;
  end

  // Pulses high for len cycles and low for len+1 between pulses, changed just after a rising edge.
  task automatic pulses(input int n, input int len);
    repeat (n) begin
      @(posedge clk);
      pulse_pin <= 1'b1;
      repeat (len) @(posedge clk);
      pulse_pin <= 1'b0;
      repeat (len) @(posedge clk);
    end
  endtask

  task automatic set_link(input logic link, input logic primary);
    @(posedge clk);
    link_pin <= link;
    primary_pin <= primary;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the pulse count link block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, want) begin checks_done++; if ((got) !== (want)) begin mismatches++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, want); end end
module tb_top;
  localparam int HALF_F = 4;
  localparam int HALF_S = 8;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [31:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [3:0]  sel = '0;
  logic [31:0] rd;
  logic        led_prev = 1'b0;
  logic        led_seen = 1'b0;
  wire logic [31:0] rdat;
  wire logic   ack, pulse_pin, link_pin, primary_pin, pulse_out, status_led, pulse_led;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          done_out = 0;
  int          high_len = 0;
  int          last_high = 0;
  int          low_len = 0;
  int          last_low = 0;
  int          toggles = 0;
  int          exp_cnt = 0;

  always #2.5 clk = ~clk;

  pulse_count_link_outage_buffer #(.HALF_FAST(HALF_F), .HALF_SLOW(HALF_S), .FILT(4), .LED_HOLD(6),
    .BLINK(5)) i_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pulse_pin(pulse_pin), .link_pin(link_pin), .primary_pin(primary_pin),
    .pulse_out(pulse_out), .status_led(status_led), .pulse_led(pulse_led));
  remote_pulse_model i_far (.clk(clk), .pulse_pin(pulse_pin), .link_pin(link_pin),
    .primary_pin(primary_pin));

  // Measures each finished output pulse and watches both lamps.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    led_prev <= status_led;
    if (status_led !== led_prev) toggles++;
    if (pulse_led === 1'b1) led_seen = 1'b1;
    if (pulse_out === 1'b1) begin
      high_len <= high_len + 1;
      if (low_len != 0) last_low <= low_len;
      low_len <= 0;
    end else begin
      low_len <= low_len + 1;
      if (high_len != 0) begin
        last_high <= high_len;
        high_len <= 0;
        done_out <= done_out + 1;
      end
    end
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic t_reset();
    wb(1'b0, 32'h0, 32'h0); `CHK(rd, 32'h0000_0000)
    wb(1'b0, 32'h4, 32'h0); `CHK(rd, 32'h0000_0000)
    wb(1'b1, 32'h8, 32'hFFFF_FFFF); wb(1'b0, 32'h8, 32'h0); `CHK(rd, 32'h0000_0000)
  endtask

  // Counting goes on with the link down, then on backup supply with the link up.
  task automatic t_offline();
    led_seen = 1'b0;
    i_far.pulses(3, 4); exp_cnt += 3; settle(10);
    `CHK(led_seen, 1'b1)
    wb(1'b0, 32'h8, 32'h0); `CHK(rd, 32'(exp_cnt))
    i_far.set_link(1'b1, 1'b0);
    i_far.pulses(2, 4); exp_cnt += 2; settle(10);
    wb(1'b0, 32'h8, 32'h0); `CHK(rd, 32'(exp_cnt))
    wb(1'b0, 32'hC, 32'h0); `CHK(rd, 32'h0000_0000)
    `CHK(done_out, 0)
  endtask

  task automatic t_restore();
    i_far.set_link(1'b1, 1'b1);
    settle(150);
    `CHK(done_out, 5)
    `CHK(last_high, HALF_F)
    `CHK(last_low, HALF_F)
    wb(1'b0, 32'hC, 32'h0); `CHK(rd, 32'h0000_0000)
    i_far.pulses(4, 4); exp_cnt += 4; settle(120);
    `CHK(done_out, 9)
  endtask

  task automatic t_slow();
    wb(1'b1, 32'h0, 32'h2);
    i_far.pulses(1, 4); exp_cnt += 1; settle(60);
    `CHK(done_out, 10)
    `CHK(last_high, HALF_S)
    toggles = 0; settle(30);
    `CHK(toggles, 0)
  endtask

  task automatic t_status();
    wb(1'b1, 32'h0, 32'h10); toggles = 0;
    i_far.pulses(1, 4); exp_cnt += 1; settle(20);
    wb(1'b0, 32'h4, 32'h0); `CHK(rd, 32'hE)
    `CHK(toggles > 2, 1'b1)
    `CHK(done_out, 10)
    wb(1'b1, 32'h0, 32'h4); toggles = 0; settle(20);
    wb(1'b0, 32'h4, 32'h0); `CHK(rd, 32'hD)
    `CHK(toggles > 2, 1'b1)
    wb(1'b1, 32'h0, 32'h8); wb(1'b0, 32'h4, 32'h0); `CHK(rd, 32'hD)
    wb(1'b1, 32'h0, 32'h1000); wb(1'b0, 32'h0, 32'h0); `CHK(rd, 32'h1000)
    wb(1'b0, 32'h4, 32'h0); `CHK(rd, 32'hE)
    wb(1'b1, 32'h0, 32'h0); i_far.set_link(1'b0, 1'b1); toggles = 0; settle(20);
    wb(1'b0, 32'h4, 32'h0); `CHK(rd, 32'h4)
    `CHK(toggles > 2, 1'b1)
  endtask

  // Short chatter is swallowed by the filter; a long pulse still counts.
  task automatic t_filter();
    wb(1'b1, 32'h0, 32'h1); settle(10); led_seen = 1'b0;
    i_far.pulses(2, 2); settle(10);
    wb(1'b0, 32'h8, 32'h0); `CHK(rd, 32'(exp_cnt))
    `CHK(led_seen, 1'b0)
    i_far.pulses(1, 8); exp_cnt += 1; settle(10);
    wb(1'b0, 32'h8, 32'h0); `CHK(rd, 32'(exp_cnt))
  endtask

  task automatic conclude();
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_offline();
    t_restore();
    t_slow();
    t_status();
    t_filter();
    conclude();
  end
endmodule
`default_nettype wire
